// ### hw/pause_field_cfg.sv
// Purpose: Holds pause and control frame fields, fills transmitted pause
//   headers and classifies received frame headers.
// Assumes: Header inputs come from logic on sys_clk_in.
// Notes: Answers on every port appear one cycle after the request.
//
// Contract
// - Global pause SA and DA are configurable, DA defaults to multicast.
// - Transmitted global pause opcode is configurable, default one.
// - Transmitted priority pause opcode is configurable, default 0x0101.
// - Global pause recognised on configured opcode match, default one.
// - Receive priority pause recognised when opcode equals configured value.
// - Receive type fields compared with configurable values, default 0x8808.
// - Transmit pause settings take effect only with transmit flow control.
// - Receive pause settings apply only with receive flow control enabled.
// - Control packets classified by opcode range, gated by receive enable.
`timescale 1ns/1ps
module pause_field_cfg
  import pause_cfg_pkg::*;
#(
  parameter int unsigned CNT_W = 8
)
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic tx_req_in,
  input wire logic tx_prio_in,
  output tx_fields_t tx_fields_out,
  input wire rx_hdr_t rx_hdr_in,
  output rx_class_t rx_class_out
);

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------
  if (CNT_W < 1 || CNT_W > 8)
  begin : g_bad_cnt
    $error("CNT_W must lie between 1 and 8");
  end

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [31:0] cfg_ff [NUM_CFG];
  logic [31:0] rdata_ff;
  logic [CNT_W-1:0] cnt_ff [4];
  wire logic [4:0] idx = reg_addr_in[6:2];
  wire logic aligned = (reg_addr_in[1:0] == 2'h0) && !reg_addr_in[7];
  wire logic cfg_hit = aligned && (idx < 5'(NUM_CFG));
  wire logic stat_hit = (reg_addr_in == ADDR_STATUS);

  // Writes land in the addressed word; status and unmapped writes drop.
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      cfg_ff <= CFG_RST;
    else if (reg_wr_in && cfg_hit)
      cfg_ff[idx] <= reg_wdata_in;
  end

  // Read selection; unmapped addresses read as zero.
  logic [31:0] nxt_rdata;
  always_comb
  begin
    if (cfg_hit)
      nxt_rdata = cfg_ff[idx];
    else if (stat_hit)
      nxt_rdata = {8'(cnt_ff[3]), 8'(cnt_ff[2]), 8'(cnt_ff[1]),
                   8'(cnt_ff[0])};
    else
      nxt_rdata = 32'h0000_0000;
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      rdata_ff <= 32'h0000_0000;
    else if (reg_rd_in)
      rdata_ff <= nxt_rdata;
    else
      rdata_ff <= 32'h0000_0000;
  end
  assign reg_rdata_out = rdata_ff;

  // ----------------------------------------------------------------------
  // Field views of the configuration words
  // ----------------------------------------------------------------------
  // Addresses pair a low word for bits 31:0 with a high word for 47:32.
  // Two 16-bit fields share a word: low half first, high half second.
  wire logic tx_fc_en = cfg_ff[IDX_CTRL][CTRL_TX_FC_BIT];
  wire logic rx_fc_en = cfg_ff[IDX_CTRL][CTRL_RX_FC_BIT];
  wire logic rx_en = cfg_ff[IDX_CTRL][CTRL_RX_EN_BIT];
  wire logic [47:0] tx_gpp_sa = {cfg_ff[IDX_TX_GPP_SA_HI][15:0],
                                 cfg_ff[IDX_TX_GPP_SA_LO]};
  wire logic [47:0] tx_gpp_da = {cfg_ff[IDX_TX_GPP_DA_HI][15:0],
                                 cfg_ff[IDX_TX_GPP_DA_LO]};
  wire logic [47:0] tx_ppp_sa = {cfg_ff[IDX_TX_PPP_SA_HI][15:0],
                                 cfg_ff[IDX_TX_PPP_SA_LO]};
  wire logic [47:0] tx_ppp_da = {cfg_ff[IDX_TX_PPP_DA_HI][15:0],
                                 cfg_ff[IDX_TX_PPP_DA_LO]};
  wire logic [47:0] rx_da_uc = {cfg_ff[IDX_RX_DA_UC_HI][15:0],
                                cfg_ff[IDX_RX_DA_UC_LO]};
  wire logic [47:0] rx_da_mc = {cfg_ff[IDX_RX_DA_MC_HI][15:0],
                                cfg_ff[IDX_RX_DA_MC_LO]};
  wire logic [15:0] tx_op_gpp = cfg_ff[IDX_TX_OPCODE][15:0];
  wire logic [15:0] tx_op_ppp = cfg_ff[IDX_TX_OPCODE][31:16];
  wire logic [15:0] rx_op_gpp = cfg_ff[IDX_RX_OPCODE][15:0];
  wire logic [15:0] rx_op_ppp = cfg_ff[IDX_RX_OPCODE][31:16];
  wire logic [15:0] gcp_min = cfg_ff[IDX_GCP_RANGE][15:0];
  wire logic [15:0] gcp_max = cfg_ff[IDX_GCP_RANGE][31:16];
  wire logic [15:0] pcp_min = cfg_ff[IDX_PCP_RANGE][15:0];
  wire logic [15:0] pcp_max = cfg_ff[IDX_PCP_RANGE][31:16];
  wire logic [15:0] tx_et_gpp = cfg_ff[IDX_TX_ETYPE][15:0];
  wire logic [15:0] tx_et_ppp = cfg_ff[IDX_TX_ETYPE][31:16];
  wire logic [15:0] rx_et_gpp = cfg_ff[IDX_RX_ETYPE_PAUSE][15:0];
  wire logic [15:0] rx_et_ppp = cfg_ff[IDX_RX_ETYPE_PAUSE][31:16];
  wire logic [15:0] rx_et_gcp = cfg_ff[IDX_RX_ETYPE_CTRL][15:0];
  wire logic [15:0] rx_et_pcp = cfg_ff[IDX_RX_ETYPE_CTRL][31:16];

  // ----------------------------------------------------------------------
  // Transmit pause header fill
  // ----------------------------------------------------------------------
  tx_fields_t tx_ff;
  tx_fields_t nxt_tx;
  wire logic tx_take = tx_req_in && tx_fc_en;

  // Priority or global field set is selected by the request.
  always_comb
  begin
    nxt_tx.valid = tx_take;
    nxt_tx.prio = tx_prio_in;
    nxt_tx.sa = tx_prio_in ? tx_ppp_sa : tx_gpp_sa;
    nxt_tx.da = tx_prio_in ? tx_ppp_da : tx_gpp_da;
    nxt_tx.opcode = tx_prio_in ? tx_op_ppp : tx_op_gpp;
    nxt_tx.etype = tx_prio_in ? tx_et_ppp : tx_et_gpp;
    if (!tx_take)
      nxt_tx = '0;
  end

  // Fields stand for one cycle per accepted request, then drop to zero.
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      tx_ff <= '0;
    else
      tx_ff <= nxt_tx;
  end
  assign tx_fields_out = tx_ff;

  // ----------------------------------------------------------------------
  // Receive classification
  // ----------------------------------------------------------------------
  // Pause recognition needs a destination match; control ignores it.
  wire logic da_ok = (rx_hdr_in.da == rx_da_uc) || (rx_hdr_in.da == rx_da_mc);
  wire logic hv = rx_hdr_in.valid;
  wire logic is_gpp = hv && rx_fc_en && da_ok
    && (rx_hdr_in.etype == rx_et_gpp)
    && (rx_hdr_in.opcode == rx_op_gpp);
  wire logic is_ppp = hv && rx_fc_en && da_ok
    && (rx_hdr_in.etype == rx_et_ppp)
    && (rx_hdr_in.opcode == rx_op_ppp);
  wire logic is_gcp = hv && rx_en && (rx_hdr_in.etype == rx_et_gcp)
    && (rx_hdr_in.opcode >= gcp_min) && (rx_hdr_in.opcode <= gcp_max);
  wire logic is_pcp = hv && rx_en && (rx_hdr_in.etype == rx_et_pcp)
    && (rx_hdr_in.opcode >= pcp_min) && (rx_hdr_in.opcode <= pcp_max);

  // One class word per header; a frame may be pause and control at once.
  rx_class_t cls_ff;
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      cls_ff <= '0;
    else
      cls_ff <= '{hv, is_gpp, is_ppp, is_gcp, is_pcp};
  end
  assign rx_class_out = cls_ff;

  // Wrapping event counters read back in the status word.
  wire logic [3:0] hit_vec = {is_pcp, is_gcp, is_ppp, is_gpp};
  for (genvar i = 0; i < 4; i++)
  begin : g_cnt
    always_ff @(posedge sys_clk_in)
    begin
      if (srst_in)
        cnt_ff[i] <= '0;
      else if (hit_vec[i])
        cnt_ff[i] <= cnt_ff[i] + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  // All checks run on the one clock and sleep through reset.
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (srst_in);

  chk_tx_global_addr: assert property (
    tx_take && !tx_prio_in |=> tx_fields_out.valid
      && tx_fields_out.da == $past(tx_gpp_da)
      && tx_fields_out.sa == $past(tx_gpp_sa))
    else $error("Global pause address fields wrong.");
  chk_tx_global_op: assert property (
    tx_take && !tx_prio_in |=> tx_fields_out.opcode == $past(tx_op_gpp))
    else $error("Global pause opcode wrong.");
  chk_tx_prio_op: assert property (
    tx_take && tx_prio_in |=> tx_fields_out.prio
      && tx_fields_out.opcode == $past(tx_op_ppp))
    else $error("Priority pause opcode wrong.");
  chk_tx_fc_gate: assert property (
    !(tx_req_in && tx_fc_en) |=> !tx_fields_out.valid)
    else $error("Pause fields issued with flow control off.");
  chk_rx_global_hit: assert property (
    hv && rx_fc_en && da_ok && rx_hdr_in.etype == rx_et_gpp
      && rx_hdr_in.opcode == rx_op_gpp |=> rx_class_out.global_pause_packet)
    else $error("Global pause frame missed.");
  chk_rx_prio_hit: assert property (
    rx_class_out.priority_pause_packet |->
      $past(rx_hdr_in.opcode) == $past(rx_op_ppp))
    else $error("Priority pause flagged on wrong opcode.");
  chk_rx_type_miss: assert property (
    hv && rx_hdr_in.etype != rx_et_gpp |=> !rx_class_out.global_pause_packet)
    else $error("Global pause flagged on wrong type.");
  chk_rx_fc_gate: assert property (
    !rx_fc_en |=> !rx_class_out.global_pause_packet
      && !rx_class_out.priority_pause_packet)
    else $error("Pause recognised with flow control off.");
  chk_ctrl_range: assert property (
    rx_class_out.global_control_packet |->
      $past(rx_hdr_in.opcode) >= $past(gcp_min)
      && $past(rx_hdr_in.opcode) <= $past(gcp_max)
      && $past(rx_hdr_in.etype) == $past(rx_et_gcp))
    else $error("Control packet outside configured range.");
  chk_ctrl_rx_en: assert property (
    hv && !rx_en |=> !rx_class_out.global_control_packet
      && !rx_class_out.priority_control_packet)
    else $error("Control packet classified with receiver off.");
  chk_read_once: assert property (
    !reg_rd_in |=> reg_rdata_out == 32'h0000_0000)
    else $error("Read data outside its cycle.");

  // ----------------------------------------------------------------------
  // Further field and timing checks
  // ----------------------------------------------------------------------
  // The priority set carries its own addresses.
  chk_tx_prio_addr: assert property (
    tx_take && tx_prio_in |=> tx_fields_out.valid
      && tx_fields_out.da == $past(tx_ppp_da)
      && tx_fields_out.sa == $past(tx_ppp_sa))
    else $error("Priority pause address fields wrong.");

  // Idle fields must be zero so that stale values never leak out.
  chk_tx_idle_zero: assert property (
    !tx_fields_out.valid |-> tx_fields_out == '0)
    else $error("Transmit fields not cleared while idle.");

  chk_rx_prio_miss: assert property (
    hv && rx_hdr_in.etype != rx_et_ppp
      |=> !rx_class_out.priority_pause_packet)
    else $error("Priority pause flagged on wrong type.");

  // Accept side of priority pause recognition.
  chk_rx_prio_take: assert property (
    hv && rx_fc_en && da_ok && rx_hdr_in.etype == rx_et_ppp
      && rx_hdr_in.opcode == rx_op_ppp
      |=> rx_class_out.priority_pause_packet)
    else $error("Priority pause frame missed.");

  // Both ends of the control range are inclusive.
  chk_gcp_take: assert property (
    hv && rx_en && rx_hdr_in.etype == rx_et_gcp
      && rx_hdr_in.opcode >= gcp_min && rx_hdr_in.opcode <= gcp_max
      |=> rx_class_out.global_control_packet)
    else $error("Global control packet missed.");

  chk_pcp_range: assert property (
    rx_class_out.priority_control_packet |->
      $past(rx_hdr_in.opcode) >= $past(pcp_min)
      && $past(rx_hdr_in.opcode) <= $past(pcp_max)
      && $past(rx_hdr_in.etype) == $past(rx_et_pcp))
    else $error("Priority control packet outside range.");

  // One class word follows every header, and only a header.
  chk_rx_valid: assert property (
    1'b1 |=> rx_class_out.valid == $past(hv))
    else $error("Class word out of step with headers.");

  // Read data carries the word selected at the strobe.
  chk_read_data: assert property (
    reg_rd_in |=> reg_rdata_out == $past(nxt_rdata))
    else $error("Read data differs from addressed word.");

  // Main scenarios that the bench should reach.
  cov_tx_prio: cover property (tx_take && tx_prio_in ##1 tx_fields_out.valid);
  cov_rx_gpp: cover property (rx_class_out.global_pause_packet);
  cov_rx_pcp: cover property (rx_class_out.priority_control_packet);
  cov_cfg_write: cover property (reg_wr_in && cfg_hit ##[1:2] reg_rd_in);
  cov_rx_ctrl_only: cover property (rx_class_out.global_control_packet
    && !rx_class_out.global_pause_packet);

endmodule

// ### inc/pause_cfg_pkg.sv
// Purpose: Shared constants and carriers for the pause field config block.
// Assumes: 32-bit register words at aligned byte addresses.
// Notes: Each configuration word sits in a table indexed by addr[6:2], with addr[7] zero.
package pause_cfg_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned NUM_CFG = 22;
  localparam logic [4:0] IDX_CTRL = 5'h00;
  localparam logic [4:0] IDX_TX_GPP_SA_LO = 5'h01;
  localparam logic [4:0] IDX_TX_GPP_SA_HI = 5'h02;
  localparam logic [4:0] IDX_TX_GPP_DA_LO = 5'h03;
  localparam logic [4:0] IDX_TX_GPP_DA_HI = 5'h04;
  localparam logic [4:0] IDX_TX_PPP_SA_LO = 5'h05;
  localparam logic [4:0] IDX_TX_PPP_SA_HI = 5'h06;
  localparam logic [4:0] IDX_TX_PPP_DA_LO = 5'h07;
  localparam logic [4:0] IDX_TX_PPP_DA_HI = 5'h08;
  localparam logic [4:0] IDX_RX_DA_UC_LO = 5'h09;
  localparam logic [4:0] IDX_RX_DA_UC_HI = 5'h0a;
  localparam logic [4:0] IDX_RX_SA_LO = 5'h0b;
  localparam logic [4:0] IDX_RX_SA_HI = 5'h0c;
  localparam logic [4:0] IDX_RX_DA_MC_LO = 5'h0d;
  localparam logic [4:0] IDX_RX_DA_MC_HI = 5'h0e;
  localparam logic [4:0] IDX_TX_OPCODE = 5'h0f;
  localparam logic [4:0] IDX_RX_OPCODE = 5'h10;
  localparam logic [4:0] IDX_GCP_RANGE = 5'h11;
  localparam logic [4:0] IDX_PCP_RANGE = 5'h12;
  localparam logic [4:0] IDX_TX_ETYPE = 5'h13;
  localparam logic [4:0] IDX_RX_ETYPE_PAUSE = 5'h14;
  localparam logic [4:0] IDX_RX_ETYPE_CTRL = 5'h15;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h58;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned CTRL_TX_FC_BIT = 0;
  localparam int unsigned CTRL_RX_FC_BIT = 1;
  localparam int unsigned CTRL_RX_EN_BIT = 2;
  localparam logic [31:0] CTRL_RST = 32'h0000_0007;
  localparam logic [47:0] PAUSE_MCAST_DA = 48'h0180_c200_0001;
  localparam logic [47:0] ZERO_ADDR = 48'h0000_0000_0000;
  localparam logic [15:0] OPCODE_GPP_RST = 16'h0001;
  localparam logic [15:0] OPCODE_PPP_RST = 16'h0101;
  localparam logic [15:0] ETYPE_CTRL_RST = 16'h8808;
  localparam logic [15:0] RANGE_MIN_RST = 16'h0000;
  localparam logic [15:0] RANGE_MAX_RST = 16'hffff;

  localparam logic [31:0] CFG_RST [NUM_CFG] = '{
    CTRL_RST,
    ZERO_ADDR[31:0], {16'h0000, ZERO_ADDR[47:32]},
    PAUSE_MCAST_DA[31:0], {16'h0000, PAUSE_MCAST_DA[47:32]},
    ZERO_ADDR[31:0], {16'h0000, ZERO_ADDR[47:32]},
    PAUSE_MCAST_DA[31:0], {16'h0000, PAUSE_MCAST_DA[47:32]},
    ZERO_ADDR[31:0], {16'h0000, ZERO_ADDR[47:32]},
    ZERO_ADDR[31:0], {16'h0000, ZERO_ADDR[47:32]},
    PAUSE_MCAST_DA[31:0], {16'h0000, PAUSE_MCAST_DA[47:32]},
    {OPCODE_PPP_RST, OPCODE_GPP_RST},
    {OPCODE_PPP_RST, OPCODE_GPP_RST},
    {RANGE_MAX_RST, RANGE_MIN_RST},
    {RANGE_MAX_RST, RANGE_MIN_RST},
    {ETYPE_CTRL_RST, ETYPE_CTRL_RST},
    {ETYPE_CTRL_RST, ETYPE_CTRL_RST},
    {ETYPE_CTRL_RST, ETYPE_CTRL_RST}
  };

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [47:0] da;
    logic [47:0] sa;
    logic [15:0] etype;
    logic [15:0] opcode;
  } rx_hdr_t;

  typedef struct packed {
    logic valid;
    logic global_pause_packet;
    logic priority_pause_packet;
    logic global_control_packet;
    logic priority_control_packet;
  } rx_class_t;

  typedef struct packed {
    logic valid;
    logic prio;
    logic [47:0] da;
    logic [47:0] sa;
    logic [15:0] etype;
    logic [15:0] opcode;
  } tx_fields_t;

endpackage

// ### tb/pause_field_cfg_bench.sv
// Purpose: Self-checking bench for the pause field config block.
// Assumes: Fixed one-cycle answers on every port.
// Notes: A shadow of the config words predicts every answer.
`timescale 1ns/1ps
module pause_field_cfg_bench
  import pause_cfg_pkg::*;
;
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic tx_req_in = 1'b0;
  logic tx_prio_in = 1'b0;
  tx_fields_t tx_fields_out;
  rx_hdr_t rx_hdr_in;
  rx_class_t rx_class_out;
  logic send = 1'b0;
  rx_hdr_t frame = '0;
  rx_hdr_t h;
  logic [31:0] sh [NUM_CFG];
  int n_errors = 0;
  int tests_run = 0;
  // Expected status counts: global pause, priority pause, controls.
  logic [7:0] hits [4] = '{default: 8'h00};

  pause_field_cfg #(.CNT_W(8)) dut (.sys_clk_in(sys_clk_in),
    .srst_in(srst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .tx_req_in(tx_req_in), .tx_prio_in(tx_prio_in),
    .tx_fields_out(tx_fields_out), .rx_hdr_in(rx_hdr_in),
    .rx_class_out(rx_class_out));
  pause_link_partner peer (.sys_clk_in(sys_clk_in), .send_in(send),
    .frame_in(frame), .hdr_out(rx_hdr_in));

  // Free-running 100 MHz clock.
  initial
  begin
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  // ----------------------------------------------------------------------
  // Prediction
  // ----------------------------------------------------------------------
  function automatic logic [47:0] a48(input int i);
    return {sh[i+1][15:0], sh[i]};
  endfunction
  function automatic tx_fields_t exp_tx(input logic p);
    tx_fields_t t;
    t = '0;
    if (sh[0][CTRL_TX_FC_BIT])
    begin
      t = {1'b1, p, p ? a48(7) : a48(3), p ? a48(5) : a48(1),
        p ? sh[19][31:16] : sh[19][15:0], p ? sh[15][31:16] : sh[15][15:0]};
    end
    return t;
  endfunction
  function automatic logic in_rng(input logic [15:0] v, input logic [31:0] r);
    return v >= r[15:0] && v <= r[31:16];
  endfunction
  function automatic rx_class_t exp_rx(input rx_hdr_t f);
    logic pz;
    logic cz;
    pz = sh[0][CTRL_RX_FC_BIT] && (f.da == a48(9) || f.da == a48(13));
    cz = sh[0][CTRL_RX_EN_BIT];
    return {1'b1,
      pz && f.etype == sh[20][15:0] && f.opcode == sh[16][15:0],
      pz && f.etype == sh[20][31:16] && f.opcode == sh[16][31:16],
      cz && f.etype == sh[21][15:0] && in_rng(f.opcode, sh[17]),
      cz && f.etype == sh[21][31:16] && in_rng(f.opcode, sh[18])};
  endfunction

  // ----------------------------------------------------------------------
  // Bus and port tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [135:0] got, input logic [135:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
    if (a[1:0] == 2'b00 && a[7:2] < NUM_CFG)
      sh[a[7:2]] = d;
  endtask
  task automatic rd(input logic [7:0] a);
    logic [31:0] e;
    e = (a[1:0] == 2'b00 && a[7:2] < NUM_CFG) ? sh[a[7:2]] : 32'h0;
    if (a == ADDR_STATUS)
      e = {hits[3], hits[2], hits[1], hits[0]};
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    check(136'(reg_rdata_out), 136'(e));
    @(posedge sys_clk_in);
    #1;
    check(136'(reg_rdata_out), 136'h0);
  endtask
  task automatic tx(input logic p);
    @(posedge sys_clk_in);
    tx_req_in <= 1'b1;
    tx_prio_in <= p;
    @(posedge sys_clk_in);
    tx_req_in <= 1'b0;
    #1;
    check(136'(tx_fields_out), 136'(exp_tx(p)));
  endtask
  task automatic rx(input rx_hdr_t f);
    rx_class_t e;
    @(posedge sys_clk_in);
    send <= 1'b1;
    frame <= f;
    @(posedge sys_clk_in);
    send <= 1'b0;
    @(posedge sys_clk_in);
    #1;
    e = exp_rx(f);
    check(136'(rx_class_out), 136'(e));
    for (int i = 0; i < 4; i++)
      hits[i] = hits[i] + 8'(e[3 - i]);
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Cuts a hang short.
  initial
  begin
    #200000;
    n_errors++;
    wrap_up();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    void'($urandom(53495));
    foreach (sh[i]) sh[i] = CFG_RST[i];
    repeat (2) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    for (int i = 0; i < NUM_CFG; i++)
      rd(8'(i * 4));
    rd(8'h02);
    rd(8'h5c);
    tx(1'b0);
    check(136'({tx_fields_out.da, tx_fields_out.opcode}),
      136'({48'h0180_c200_0001, 16'h0001}));
    tx(1'b1);
    check(136'(tx_fields_out.opcode), 136'h0101);
    h = {1'b1, PAUSE_MCAST_DA, 48'h0, 16'h8808, 16'h0001};
    rx(h);
    check(136'({rx_class_out.global_pause_packet,
      rx_class_out.global_control_packet}), 136'h3);
    rx({h[128:16], 16'h0101});
    wr(8'h00, 32'h6);
    tx(1'b0);
    wr(8'h00, 32'h5);
    rx(h);
    wr(8'h00, 32'h3);
    rx(h);
    wr(8'h00, 32'h7);
    wr(8'h58, 32'hffff_ffff);
    wr(8'h06, 32'h1234_5678);
    rd(8'h04);
    wr(8'h44, 32'h0200_0100);
    wr(8'h48, 32'h0010_0020);
    for (int i = 0; i < 4; i++)
      rx({h[128:16], 16'h00ff + 16'(i)});
    rx({h[128:16], 16'h0200});
    rx({h[128:16], 16'h0201});
    wr(8'h54, 32'h8808_1234);
    rx({h[128:16], 16'h0100});
    rd(ADDR_STATUS);
    repeat (80)
    begin
      logic [15:0] op [7];
      op = '{sh[16][15:0], sh[16][31:16], sh[17][15:0], sh[17][31:16],
        sh[18][15:0], sh[18][31:16], 16'($urandom)};
      case ($urandom_range(3))
        0: wr(8'($urandom_range(NUM_CFG - 1) * 4), $urandom);
        1: tx(1'($urandom));
        2: rx({1'b1, $urandom_range(1) ? a48(9) : a48(13),
          48'($urandom),
          16'(sh[20 + $urandom_range(1)] >> (16 * $urandom_range(1))),
          16'(op[$urandom_range(6)] +
          $urandom_range(2) - 1)});
        default: rd(8'($urandom_range(NUM_CFG) * 4));
      endcase
    end
    // A mid-run reset must bring back every default and clear the counts.
    @(posedge sys_clk_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    foreach (sh[i]) sh[i] = CFG_RST[i];
    hits = '{default: 8'h00};
    rd(ADDR_STATUS);
    rd(8'h0c);
    tx(1'b0);
    rx(h);
    rd(ADDR_STATUS);
    wrap_up();
  end
endmodule

// ### tb/pause_link_partner.sv
// Purpose: Link partner model that delivers received frame headers.
// Assumes: A header is launched on the same edge that samples send_in high.
// Notes: Between frames valid is low and the header fields invert their previous value every cycle.
`timescale 1ns/1ps
module pause_link_partner
  import pause_cfg_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic send_in,
  input wire rx_hdr_t frame_in,
  output rx_hdr_t hdr_out
);
  // ----------------------------------------------------------------------
  // Frame launch
  // ----------------------------------------------------------------------
  // A header stands one cycle; stale fields are scrambled afterwards.
  always_ff @(posedge sys_clk_in)
  begin
    if (send_in)
      hdr_out <= {1'b1, frame_in[127:0]};
    else
      hdr_out <= {1'b0, ~hdr_out[127:0]};
  end
endmodule
